// [skip_and_set_instruction_exec_test.sv]
// self-checking bench for the skip and set executor
`timescale 1ns/100ps
module skip_and_set_instruction_exec_test;
    import ssk_pkg::*;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic start = 1'h0;
    logic [OP_W-1:0] op = 3'h0;
    logic [ADDR_W-1:0] addr = 9'h000;
    logic [BIT_W-1:0] bit_sel = 3'h0;
    logic busy, done, skip_taken, dummy_insert, illegal_op, mem_rd_en, mem_wr_en;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] mem_rd_data, mem_wr_data, accumulator;
    logic [DATA_W-1:0] acc_e = 8'h00;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    ssk_exec uut (.clk(clk), .rst(rst), .start(start), .op(op), .addr(addr), .bit_sel(bit_sel),
        .busy(busy), .done(done), .skip_taken(skip_taken), .dummy_insert(dummy_insert),
        .illegal_op(illegal_op), .mem_rd_en(mem_rd_en), .mem_addr(mem_addr),
        .mem_rd_data(mem_rd_data), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data),
        .accumulator(accumulator));
    ssk_mem_model mem (.clk(clk), .rd_en(mem_rd_en), .addr(mem_addr), .rd_data(mem_rd_data),
        .wr_en(mem_wr_en), .wr_data(mem_wr_data));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            stop_test();
        end
    end
    // =========================================================
    // shared tasks
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    task automatic run(input logic [OP_W-1:0] o, input logic [ADDR_W-1:0] a,
        input logic [BIT_W-1:0] b, input logic [7:0] init, input logic [7:0] exp_m,
        input logic sk);
        int n;
        int d;
        n = 0;
        d = 0;
        mem.data[a] = init;
        @(posedge clk);
        start <= 1'h1;
        op <= o;
        addr <= a;
        bit_sel <= b;
        @(posedge clk);
        start <= 1'h0;
        for (int k = 0; k < 8 && done !== 1'h1; k++) begin
            @(posedge clk);
            #1;
            n++;
            if (dummy_insert === 1'h1) begin
                d++;
            end
        end
        chk(9'(n), sk ? 9'(CYCLES_SKIP) : 9'(CYCLES_PLAIN));
        chk(9'(d), 9'(sk));
        chk(9'(skip_taken), 9'(sk));
        @(posedge clk);
        #1;
        chk(9'(mem.data[a]), 9'(exp_m));
        chk(9'(accumulator), 9'(acc_e));
    endtask : run
    // =========================================================
    // scenarios
    task automatic t_dec();
        run(OP_DEC_SKIP_ZERO_MEM, 9'h010, 3'h0, 8'h05, 8'h04, 1'h0);
        run(OP_DEC_SKIP_ZERO_MEM, 9'h1FF, 3'h0, 8'h01, 8'h00, 1'h1);
        run(OP_DEC_SKIP_ZERO_MEM, 9'h000, 3'h0, 8'h00, 8'hFF, 1'h0);
        acc_e = 8'h0F;
        run(OP_DEC_SKIP_ZERO_TO_ACC, 9'h020, 3'h0, 8'h10, 8'h10, 1'h0);
        acc_e = 8'h00;
        run(OP_DEC_SKIP_ZERO_TO_ACC, 9'h021, 3'h0, 8'h01, 8'h01, 1'h1);
    endtask : t_dec
    task automatic t_inc();
        run(OP_INC_SKIP_ZERO_MEM, 9'h030, 3'h0, 8'hFF, 8'h00, 1'h1);
        run(OP_INC_SKIP_ZERO_MEM, 9'h031, 3'h0, 8'h7F, 8'h80, 1'h0);
        acc_e = 8'h00;
        run(OP_INC_SKIP_ZERO_TO_ACC, 9'h032, 3'h0, 8'hFF, 8'hFF, 1'h1);
        acc_e = 8'h01;
        run(OP_INC_SKIP_ZERO_TO_ACC, 9'h033, 3'h0, 8'h00, 8'h00, 1'h0);
    endtask : t_inc
    task automatic t_set();
        run(OP_SET_BYTE, 9'h040, 3'h0, 8'h3C, 8'hFF, 1'h0);
        for (int i = 0; i < 8; i++) begin
            run(OP_SET_BIT, 9'h050 + 9'(i), 3'(i), 8'h5A, 8'h5A | (8'h01 << i), 1'h0);
        end
    endtask : t_set
    task automatic t_bit_test();
        for (int i = 0; i < 8; i++) begin
            run(OP_SKIP_IF_BIT_NONZERO, 9'h080, 3'(i), 8'hA5, 8'hA5, 1'(8'hA5 >> i));
        end
    endtask : t_bit_test
    task automatic t_illegal();
        run(3'h7, 9'h0C0, 3'h0, 8'h33, 8'h33, 1'h0);
        chk(9'(illegal_op), 9'h001);
    endtask : t_illegal
    initial begin
        repeat (5) @(posedge clk);
        #1;
        chk(9'({busy, done, skip_taken, mem_wr_en}), 9'h000);
        rst <= 1'h0;
        t_dec();
        t_inc();
        t_set();
        t_bit_test();
        t_illegal();
        stop_test();
    end
endmodule : skip_and_set_instruction_exec_test
bind ssk_exec ssk_monitor mon (.clk(clk), .rst(rst), .start(start), .op(op), .addr(addr),
    .bit_sel(bit_sel), .busy(busy), .done(done), .skip_taken(skip_taken),
    .dummy_insert(dummy_insert), .illegal_op(illegal_op), .mem_rd_en(mem_rd_en),
    .mem_addr(mem_addr), .mem_rd_data(mem_rd_data), .mem_wr_en(mem_wr_en),
    .mem_wr_data(mem_wr_data), .accumulator(accumulator));

// [ssk_alu.sv]
// byte operation unit: result, destination and skip decision
`timescale 1ns/100ps
module ssk_alu
    import ssk_pkg::*;
(
    ssk_alu_if.unit alu
);

    logic [DATA_W-1:0] inc_val;
    logic [DATA_W-1:0] dec_val;
    logic [DATA_W-1:0] mask;

    // =========================================================
    // arithmetic
    assign inc_val = DATA_W'(alu.operand + BYTE_ONE);
    assign dec_val = DATA_W'(alu.operand - BYTE_ONE);
    assign mask = ssk_bit_mask(alu.bit_sel);

    // =========================================================
    // decode
    always_comb begin
        alu.result = alu.operand;
        alu.to_mem = 1'b0;
        alu.to_acc = 1'b0;
        alu.skip = 1'b0;
        alu.illegal = 1'b0;
        unique case (alu.op)
            OP_DEC_SKIP_ZERO_MEM: begin
                alu.result = dec_val;
                alu.to_mem = 1'b1;
                alu.skip = (dec_val == BYTE_ZERO);
            end
            OP_DEC_SKIP_ZERO_TO_ACC: begin
                alu.result = dec_val;
                alu.to_acc = 1'b1;
                alu.skip = (dec_val == BYTE_ZERO);
            end
            OP_SET_BYTE: begin
                alu.result = BYTE_ALL_ONES;
                alu.to_mem = 1'b1;
            end
            OP_SET_BIT: begin
                alu.result = alu.operand | mask;
                alu.to_mem = 1'b1;
            end
            OP_INC_SKIP_ZERO_MEM: begin
                alu.result = inc_val;
                alu.to_mem = 1'b1;
                alu.skip = (inc_val == BYTE_ZERO);
            end
            OP_INC_SKIP_ZERO_TO_ACC: begin
                alu.result = inc_val;
                alu.to_acc = 1'b1;
                alu.skip = (inc_val == BYTE_ZERO);
            end
            OP_SKIP_IF_BIT_NONZERO: begin
                alu.skip = ((alu.operand & mask) != BYTE_ZERO);
            end
            default: begin
                alu.illegal = 1'b1;
            end
        endcase
    end

endmodule : ssk_alu

// [ssk_alu_if.sv]
// link between the sequencer and the byte operation unit
`timescale 1ns/100ps
interface ssk_alu_if;
    import ssk_pkg::*;

    logic [OP_W-1:0] op;
    logic [DATA_W-1:0] operand;
    logic [BIT_W-1:0] bit_sel;
    logic [DATA_W-1:0] result;
    logic to_mem;
    logic to_acc;
    logic skip;
    logic illegal;

    modport seq (
        output op,
        output operand,
        output bit_sel,
        input result,
        input to_mem,
        input to_acc,
        input skip,
        input illegal
    );

    modport unit (
        input op,
        input operand,
        input bit_sel,
        output result,
        output to_mem,
        output to_acc,
        output skip,
        output illegal
    );
endinterface : ssk_alu_if

// [ssk_exec.sv]
// sequencer for the skip and set instructions
`timescale 1ns/100ps
module ssk_exec
    import ssk_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // instruction request from the fetch sequencer
    input wire logic start,
    input wire logic [OP_W-1:0] op,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [BIT_W-1:0] bit_sel,
    // status back to the fetch sequencer
    output logic busy,
    output logic done,
    output logic skip_taken,
    output logic dummy_insert,
    output logic illegal_op,
    // data memory
    output logic mem_rd_en,
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] mem_rd_data,
    output logic mem_wr_en,
    output logic [DATA_W-1:0] mem_wr_data,
    // accumulator
    output logic [DATA_W-1:0] accumulator
);

    // =========================================================
    // state
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_READ = 4'h2,
        ST_EXEC = 4'h4,
        ST_DUMMY = 4'h8
    } ssk_state_t;

    ssk_state_t state;
    ssk_state_t next_state;
    logic [OP_W-1:0] op_q;
    logic [BIT_W-1:0] bit_q;

    ssk_alu_if alu_link ();

    // =========================================================
    // operation unit
    ssk_alu u_alu (
        .alu(alu_link.unit)
    );

    assign alu_link.op = op_q;
    assign alu_link.operand = mem_rd_data;
    assign alu_link.bit_sel = bit_q;

    // =========================================================
    // next state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_READ;
                end
            end
            ST_READ: begin
                next_state = ST_EXEC;
            end
            ST_EXEC: begin
                if (alu_link.skip) begin
                    next_state = ST_DUMMY;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_DUMMY: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // =========================================================
    // request capture
    always_ff @(posedge clk) begin
        if (rst) begin
            op_q <= OP_W'(OP_DEC_SKIP_ZERO_MEM);
            bit_q <= '0;
            mem_addr <= ADDR_RESET;
        end else if (state == ST_IDLE && start) begin
            op_q <= op;
            bit_q <= bit_sel;
            mem_addr <= addr;
        end
    end

    // =========================================================
    // memory read strobe, one cycle in the read state
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_rd_en <= 1'b0;
        end else begin
            mem_rd_en <= (state == ST_IDLE) && start;
        end
    end

    // =========================================================
    // memory write back
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_wr_en <= 1'b0;
            mem_wr_data <= BYTE_ZERO;
        end else begin
            mem_wr_en <= 1'b0;
            if (state == ST_EXEC && alu_link.to_mem) begin
                mem_wr_en <= 1'b1;
                mem_wr_data <= alu_link.result;
            end
        end
    end

    // =========================================================
    // accumulator; memory byte left alone in these forms
    always_ff @(posedge clk) begin
        if (rst) begin
            accumulator <= ACC_RESET;
        end else if (state == ST_EXEC && alu_link.to_acc) begin
            accumulator <= alu_link.result;
        end
    end

    // =========================================================
    // skip result, held until the next request
    always_ff @(posedge clk) begin
        if (rst) begin
            skip_taken <= 1'b0;
            illegal_op <= 1'b0;
        end else if (state == ST_IDLE && start) begin
            skip_taken <= 1'b0;
            illegal_op <= 1'b0;
        end else if (state == ST_EXEC) begin
            skip_taken <= alu_link.skip;
            illegal_op <= alu_link.illegal;
        end
    end

    // =========================================================
    // completion pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            done <= 1'b0;
        end else begin
            done <= (state == ST_EXEC && !alu_link.skip) || (state == ST_DUMMY);
        end
    end

    // =========================================================
    // handshake outputs
    assign busy = (state != ST_IDLE);
    assign dummy_insert = (state == ST_DUMMY);

endmodule : ssk_exec

// [ssk_mem_model.sv]
// data memory model on the far side of the executor
`timescale 1ns/100ps
module ssk_mem_model
    import ssk_pkg::*;
(
    // clock
    input wire logic clk,
    // memory port
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [DATA_W-1:0] wr_data
);
    logic [DATA_W-1:0] data [2**ADDR_W];
    // read data valid one cycle, toggling garbage otherwise
    always @(posedge clk) begin
        rd_data <= rd_en ? data[addr] : ~rd_data;
        if (wr_en) begin
            data[addr] <= wr_data;
        end
    end
endmodule : ssk_mem_model

// [ssk_monitor.sv]
// assertions on the executor ports
`timescale 1ns/100ps
module ssk_monitor
    import ssk_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request
    input wire logic start,
    input wire logic [OP_W-1:0] op,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [BIT_W-1:0] bit_sel,
    // status
    input wire logic busy,
    input wire logic done,
    input wire logic skip_taken,
    input wire logic dummy_insert,
    input wire logic illegal_op,
    // memory and accumulator
    input wire logic mem_rd_en,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] mem_rd_data,
    input wire logic mem_wr_en,
    input wire logic [DATA_W-1:0] mem_wr_data,
    input wire logic [DATA_W-1:0] accumulator
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic go;
    assign go = start && !busy;
    property p_set_bit;
        logic [BIT_W-1:0] b;
        (go && op == OP_SET_BIT, b = bit_sel) |-> ##3 mem_wr_en
            && mem_wr_data == ($past(mem_rd_data) | (8'h01 << b));
    endproperty
    property p_bit_test;
        logic [BIT_W-1:0] b;
        (go && op == OP_SKIP_IF_BIT_NONZERO, b = bit_sel) |-> ##3 !mem_wr_en
            && skip_taken == |($past(mem_rd_data) & (8'h01 << b));
    endproperty
    // =========================================================
    // assertions
    a_read_first: assert property (go |=> mem_rd_en && busy && mem_addr == $past(addr))
        else $error("no read after start");
    a_end_time: assert property (go |-> ##3 (done ^ dummy_insert))
        else $error("wrong end cycle");
    a_dummy_done: assert property (dummy_insert |=> done && !busy && !dummy_insert)
        else $error("no done after dummy");
    a_skip_dummy: assert property ($rose(skip_taken) |-> dummy_insert)
        else $error("skip without dummy");
    a_dec_write: assert property (go && op == OP_DEC_SKIP_ZERO_MEM |-> ##3 mem_wr_en
        && mem_wr_data == $past(mem_rd_data) - 8'h01 && skip_taken == (mem_wr_data == 8'h00))
        else $error("bad decrement write");
    a_inc_acc: assert property (go && op == OP_INC_SKIP_ZERO_TO_ACC |-> ##3 !mem_wr_en
        && accumulator == $past(mem_rd_data) + 8'h01 && skip_taken == (accumulator == 8'h00))
        else $error("bad increment to accumulator");
    a_set_byte: assert property (go && op == OP_SET_BYTE |-> ##3 mem_wr_en
        && mem_wr_data == 8'hFF && !skip_taken)
        else $error("bad byte set");
    a_set_bit: assert property (p_set_bit)
        else $error("bad bit set");
    a_bit_test: assert property (p_bit_test)
        else $error("bad bit test skip");
    c_skip: cover property (dummy_insert);
    c_plain: cover property (done && !skip_taken);
    c_illegal: cover property (done && illegal_op);
endmodule : ssk_monitor

// [ssk_pkg.sv]
// constants and types shared by the skip-and-set instruction executor
package ssk_pkg;

    // =========================================================
    // widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 9;
    localparam int BIT_W = 3;
    localparam int OP_W = 3;

    // =========================================================
    // data constants
    localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ALL_ONES = 8'hFF;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;

    // =========================================================
    // cycle counts
    localparam int CYCLES_PLAIN = 2;
    localparam int CYCLES_SKIP = 3;

    // =========================================================
    // instruction codes
    typedef enum logic [OP_W-1:0] {
        OP_DEC_SKIP_ZERO_MEM = 3'h0,
        OP_DEC_SKIP_ZERO_TO_ACC = 3'h1,
        OP_SET_BYTE = 3'h2,
        OP_SET_BIT = 3'h3,
        OP_INC_SKIP_ZERO_MEM = 3'h4,
        OP_INC_SKIP_ZERO_TO_ACC = 3'h5,
        OP_SKIP_IF_BIT_NONZERO = 3'h6
    } ssk_op_t;

    // =========================================================
    // one-hot mask of a bit position
    function automatic logic [DATA_W-1:0] ssk_bit_mask(input logic [BIT_W-1:0] sel);
        logic [DATA_W-1:0] m;
        m = BYTE_ONE << sel;
        return m;
    endfunction : ssk_bit_mask

endpackage : ssk_pkg
